// File: rtl/flash_cmd_ctrl.v
// Serial flash command interpreter: chip erase, deep sleep, identification, secure sectors
`timescale 1ns/1ps
`include "flash_cmd_consts.vh"
// Summary of operation
// - Chip erase on C7/60 needs latch set
// - Chip erase dropped unless select rises at bit 8
// - Select rise starts erase; busy flag; latch clears
// - Chip erase ignored when any block protected
// - B9 enters deep sleep; blocks writes there
// - Deep sleep ignores all but release command
// - Sleep entry exactly at bit 8, after delay
// - Sleep command rejected while busy
// - Reset always starts in standby
// - Release alone in standby waits wake delay then accepts
// - AB plus three dummies repeats signature MSB first
// - Release from sleep waits signature wake delay
// - Release command not decoded while busy, except to leave deep sleep
// - 90 with address gives maker/device code order
// - 9F shifts maker, type, capacity bytes
// - 9F not decoded while busy
// - 3A enters secure mode; status remapped
// - Secure mode rejects chip erase
// - Secure lock bits set once, never cleared
// - 04 exits secure mode
// - Quad mode sends bytes as two nibbles
module flash_cmd_ctrl #(
  parameter [7:0] SIGNATURE = 8'h12,
  parameter [7:0] MAKER_CODE = 8'h5A,
  parameter [7:0] MEM_TYPE = 8'h30,
  parameter [7:0] CAPACITY = 8'h13,
  parameter ERASE_CYC = `ERASE_CYC_DEFAULT
)
(
  // Clock and reset
  input wire i_clk,
  input wire i_rstn,
  // Serial pins from host
  input wire i_cs_n,
  input wire i_sclk,
  input wire [3:0] i_dq,
  // Serial data out (enable low while driving)
  output reg [3:0] o_dq,
  output reg [3:0] o_dq_oe_n,
  // Mode and protection inputs from neighbouring logic
  input wire i_quad_peripheral_mode,
  input wire i_any_block_protected,
  input wire i_write_enable_set,
  input wire i_other_busy,
  // State outputs
  output reg o_write_enable_latch,
  output reg o_write_in_progress,
  output reg o_deep_sleep,
  output reg o_secure_mode,
  output reg o_chip_erase_start,
  output reg [7:0] o_secure_status,
  output reg [2:0] o_sector_lock,
  output reg o_extra_lock_bit
);
  // ****************************************
  // Input synchronisers and edge detection
  // ****************************************
  reg [1:0] cs_sync_reg, clk_sync_reg;
  reg [3:0] dq_s1_reg, dq_s2_reg;
  reg cs_d_reg, clk_d_reg;
  // Two flops on every pin; the first stage is read by nothing else
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      cs_sync_reg <= 2'h3;
      clk_sync_reg <= 2'h0;
      dq_s1_reg <= 4'h0;
      dq_s2_reg <= 4'h0;
      cs_d_reg <= 1'b1;
      clk_d_reg <= 1'b0;
    end
    else
    begin
      cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
      clk_sync_reg <= {clk_sync_reg[0], i_sclk};
      dq_s1_reg <= i_dq;
      dq_s2_reg <= dq_s1_reg;
      cs_d_reg <= cs_sync_reg[1];
      clk_d_reg <= clk_sync_reg[1];
    end
  end
  wire cs_n = cs_sync_reg[1];
  wire cs_rise = cs_n & ~cs_d_reg;
  wire sclk_rise = ~cs_n & clk_sync_reg[1] & ~clk_d_reg;
  wire sclk_fall = ~cs_n & ~clk_sync_reg[1] & clk_d_reg;

  // ****************************************
  // Frame shifter and decode
  // ****************************************
  reg [5:0] bits_reg;
  reg [7:0] op_reg;
  reg [31:0] shift_reg;
  reg [23:0] out_reg;
  reg [4:0] out_len_reg;
  reg [4:0] out_cnt_reg;
  reg out_on_reg;
  reg [15:0] wait_reg;
  reg sleep_pend_reg;
  reg [31:0] erase_cnt_reg;
  wire quad = i_quad_peripheral_mode;
  wire busy = o_write_in_progress | i_other_busy;
  // Quad mode moves a nibble per edge, MSB nibble first
  wire [5:0] step = quad ? 6'd4 : 6'd1;
  wire [31:0] shifted = quad ? {shift_reg[27:0], dq_s2_reg} : {shift_reg[30:0], dq_s2_reg[0]};
  wire [5:0] bits_next = (bits_reg > 6'd55) ? bits_reg : bits_reg + step;
  wire op_done = (bits_reg == 6'd8);
  wire accept = (wait_reg == 16'h0) & ~sleep_pend_reg;
  wire [7:0] op = op_reg;
  wire [23:0] out_rot = quad ? {out_reg[19:0], out_reg[23:20]} : {out_reg[22:0], out_reg[23]};
  // Wait figures are cut to the 16-bit wait counter; all of them fit with room to spare
  localparam [31:0] SLEEP_WAIT = `SLEEP_ENTRY_CYC;
  localparam [31:0] WAKE_WAIT = `WAKE_CYC;
  localparam [31:0] WAKE_SIG_WAIT = `WAKE_SIG_CYC;
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      bits_reg <= 6'h0;
      op_reg <= 8'h00;
      shift_reg <= 32'h0;
      out_on_reg <= 1'b0;
      out_reg <= 24'h0;
      out_len_reg <= 5'h0;
      out_cnt_reg <= 5'h0;
      o_dq <= 4'h0;
      o_dq_oe_n <= 4'hF;
    end
    else if (cs_n)
    begin
      bits_reg <= 6'h0;
      out_on_reg <= 1'b0;
      out_cnt_reg <= 5'h0;
      o_dq_oe_n <= 4'hF;
    end
    else
    begin
      if (sclk_rise)
      begin
        shift_reg <= shifted;
        bits_reg <= bits_next;
        if (bits_next == 6'd8)
          op_reg <= shifted[7:0];
        // Output begins once opcode plus any address/dummy bytes are in
        if (accept && !out_on_reg)
        begin
          // Decode from the incoming byte: the opcode register still holds the last frame's
          if (shifted[7:0] == `OP_IDENT_READ && bits_next == 6'd8 && !busy && !o_deep_sleep)
          begin
            out_on_reg <= 1'b1;
            out_reg <= {MAKER_CODE, MEM_TYPE, CAPACITY};
            out_len_reg <= 5'd24;
          end
          if (op_reg == `OP_RELEASE_SIG && bits_next == 6'd32 && !busy)
          begin
            out_on_reg <= 1'b1;
            out_reg <= {SIGNATURE, SIGNATURE, SIGNATURE};
            out_len_reg <= 5'd8;
          end
          if (op_reg == `OP_MFR_DEV_ID && bits_next == 6'd32 && !busy && !o_deep_sleep)
          begin
            out_on_reg <= 1'b1;
            out_reg <= shifted[0] ? {SIGNATURE, MAKER_CODE, SIGNATURE}
                                  : {MAKER_CODE, SIGNATURE, MAKER_CODE};
            out_len_reg <= 5'd16;
          end
        end
      end
      if (sclk_fall && out_on_reg)
      begin
        o_dq_oe_n <= quad ? 4'h0 : 4'hD;
        if (quad)
        begin
          o_dq <= out_reg[23:20];
          out_reg <= {out_reg[19:0], out_reg[23:20]};
        end
        else
        begin
          o_dq <= {2'b00, out_reg[23], 1'b0};
          out_reg <= {out_reg[22:0], out_reg[23]};
        end
        // Wrap so the byte sequence repeats until select rises
        if (out_cnt_reg + (quad ? 5'd4 : 5'd1) >= out_len_reg)
        begin
          out_cnt_reg <= 5'h0;
          // Rotate the two-byte pattern back so the pair order holds on repeat
          if (out_len_reg == 5'd24)
            out_reg <= {MAKER_CODE, MEM_TYPE, CAPACITY};
          else if (out_len_reg == 5'd16)
            out_reg <= {out_rot[23:16], out_rot[7:0], out_rot[15:8]};
        end
        else
          out_cnt_reg <= out_cnt_reg + (quad ? 5'd4 : 5'd1);
      end
    end
  end

  // ****************************************
  // Command execution on select rise
  // ****************************************
  wire erase_ok = op_done & (op == `OP_CHIP_ERASE_A | op == `OP_CHIP_ERASE_B);
  // Status write in secure mode: the data byte is the last eight bits shifted in
  wire cs_rush_lock = cs_rise & accept & o_secure_mode & ~busy & ~o_deep_sleep
                      & (op == `OP_STATUS_WRITE) & (bits_reg == 6'd16);
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      o_write_enable_latch <= 1'b0;
      o_write_in_progress <= 1'b0;
      o_deep_sleep <= 1'b0;
      o_secure_mode <= 1'b0;
      o_chip_erase_start <= 1'b0;
      o_sector_lock <= 3'h0;
      o_extra_lock_bit <= 1'b0;
      o_secure_status <= 8'h00;
      wait_reg <= 16'h0;
      sleep_pend_reg <= 1'b0;
      erase_cnt_reg <= 32'h0;
    end
    else
    begin
      o_chip_erase_start <= 1'b0;
      o_secure_status <= {o_sector_lock[0], 3'b000, o_extra_lock_bit, o_sector_lock[1],
                          o_sector_lock[2], o_write_in_progress};
      // One counter times sleep entry and both wake delays
      if (wait_reg != 16'h0)
        wait_reg <= wait_reg - 16'h1;
      if (sleep_pend_reg && wait_reg == 16'h1)
      begin
        o_deep_sleep <= 1'b1;
        sleep_pend_reg <= 1'b0;
      end
      // Latch drops halfway, well before the busy flag falls
      if (o_write_in_progress)
      begin
        if (erase_cnt_reg == 32'h1)
          o_write_in_progress <= 1'b0;
        if (erase_cnt_reg == ERASE_CYC / 2)
          o_write_enable_latch <= 1'b0;
        erase_cnt_reg <= erase_cnt_reg - 32'h1;
      end
      // The latch still sets in secure mode, though no command there checks it
      if (i_write_enable_set && !o_deep_sleep)
        o_write_enable_latch <= 1'b1;
      if (cs_rise && accept && op_done)
      begin
        if (o_deep_sleep)
        begin
          if (op == `OP_RELEASE_SIG)
          begin
            o_deep_sleep <= 1'b0;
            wait_reg <= WAKE_SIG_WAIT[15:0];
          end
        end
        // Commands act only on a select rise with nothing running
        else if (!busy)
        begin
          case (op)
            `OP_CHIP_ERASE_A, `OP_CHIP_ERASE_B:
              if (erase_ok && o_write_enable_latch && !i_any_block_protected
                  && !o_secure_mode)
              begin
                o_write_in_progress <= 1'b1;
                o_chip_erase_start <= 1'b1;
                erase_cnt_reg <= ERASE_CYC;
              end
            `OP_DEEP_SLEEP:
            begin
              sleep_pend_reg <= 1'b1;
              wait_reg <= SLEEP_WAIT[15:0];
            end
            `OP_RELEASE_SIG:
              wait_reg <= WAKE_WAIT[15:0];
            `OP_SECURE_ENTER:
              o_secure_mode <= 1'b1;
            `OP_WRITE_DISABLE:
            begin
              o_secure_mode <= 1'b0;
              o_write_enable_latch <= 1'b0;
            end
            default:
              wait_reg <= wait_reg;
          endcase
        end
      end
      // Lock bits only OR in ones, so they can never clear
      if (cs_rush_lock)
      begin
        o_sector_lock <= o_sector_lock | {shift_reg[1], shift_reg[2], shift_reg[7]};
        o_extra_lock_bit <= o_extra_lock_bit | shift_reg[3];
      end
    end
  end
endmodule // flash_cmd_ctrl

// File: rtl/flash_cmd_consts.vh
// Opcodes, timing figures and field positions for the flash command interpreter
`ifndef FLASH_CMD_CONSTS_VH
`define FLASH_CMD_CONSTS_VH
`define OP_CHIP_ERASE_A 8'hC7
`define OP_CHIP_ERASE_B 8'h60
`define OP_DEEP_SLEEP 8'hB9
`define OP_RELEASE_SIG 8'hAB
`define OP_MFR_DEV_ID 8'h90
`define OP_IDENT_READ 8'h9F
`define OP_SECURE_ENTER 8'h3A
`define OP_WRITE_DISABLE 8'h04
`define OP_WRITE_ENABLE 8'h06
`define OP_STATUS_WRITE 8'h01
`define OP_STATUS_READ 8'h05
`define OP_SECTOR_ERASE 8'h20
`define OP_BLOCK_ERASE 8'hD8
`define OP_HALF_BLOCK_ERASE 8'h52
`define CLK_NS 50
`define SLEEP_ENTRY_NS 3000
`define SLEEP_ENTRY_CYC ((`SLEEP_ENTRY_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_NS 3000
`define WAKE_CYC ((`WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`define WAKE_SIG_NS 1800
`define WAKE_SIG_CYC ((`WAKE_SIG_NS + `CLK_NS - 1) / `CLK_NS)
`define ERASE_CYC_DEFAULT 40000000
`define SR_LOCK0_BIT 7
`define SR_EXTRA_LOCK_BIT 3
`define SR_LOCK1_BIT 2
`define SR_LOCK2_BIT 1
`define SR_WIP_BIT 0
`define SR_WEL_BIT 1
`define SEC_BASE_0 24'h07F000
`define SEC_BASE_1 24'h07E000
`define SEC_BASE_2 24'h07D000
`endif

// File: tb/flash_cmd_ctrl_assertions.sv
// Port-level concurrent checks for the flash command interpreter
`timescale 1ns/1ps
module flash_cmd_ctrl_assertions #(
  parameter ERASE_CYC = 400
)
(
  // Clock, reset and inputs
  input wire i_clk,
  input wire i_rstn,
  input wire i_cs_n,
  input wire i_any_block_protected,
  // Observed outputs
  input wire [3:0] o_dq_oe_n,
  input wire o_write_enable_latch,
  input wire o_write_in_progress,
  input wire o_deep_sleep,
  input wire o_secure_mode,
  input wire o_chip_erase_start,
  input wire [7:0] o_secure_status,
  input wire [2:0] o_sector_lock,
  input wire o_extra_lock_bit
);
  integer run_cnt;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);
  // Busy length counter; busy lasts exactly ERASE_CYC cycles, the check allows one cycle either way
  always @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
      run_cnt <= 0;
    else if (o_write_in_progress)
      run_cnt <= run_cnt + 1;
    else
      run_cnt <= 0;
  end
  a_erase_length: assert property ($fell(o_write_in_progress) |->
    run_cnt >= ERASE_CYC - 1 && run_cnt <= ERASE_CYC + 1) else $error("bad busy length");
  a_wel_cleared: assert property ($fell(o_write_in_progress) |->
    !o_write_enable_latch) else $error("latch left set");
  a_erase_needs_wel: assert property ($rose(o_write_in_progress) |->
    $past(o_write_enable_latch)) else $error("erase without latch");
  a_erase_gated: assert property ($rose(o_write_in_progress) |->
    !$past(i_any_block_protected) && !$past(o_secure_mode) && !$past(o_deep_sleep))
    else $error("erase while barred");
  a_sleep_when_idle: assert property ($rose(o_deep_sleep) |->
    !o_write_in_progress && i_cs_n) else $error("sleep during busy");
  a_oe_deselect: assert property (i_cs_n [*8] |-> o_dq_oe_n == 4'hF)
    else $error("driving while deselected");
  a_lock_sticky: assert property (1'b1 |->
    (o_sector_lock | ~$past(o_sector_lock)) == 3'h7) else $error("lock bit cleared");
  a_extra_sticky: assert property ($past(o_extra_lock_bit) |-> o_extra_lock_bit)
    else $error("extra lock cleared");
  a_status_map: assert property (o_secure_mode |->
    o_secure_status == {$past(o_sector_lock[0]), 3'h0, $past(o_extra_lock_bit),
    $past(o_sector_lock[1]), $past(o_sector_lock[2]), $past(o_write_in_progress)})
    else $error("status map wrong");
  c_erase: cover property (o_chip_erase_start);
  c_sleep: cover property ($rose(o_deep_sleep));
  c_secure: cover property ($rose(o_secure_mode));
endmodule // flash_cmd_ctrl_assertions

// File: tb/spi_host_model.sv
// Host serial controller model driving the flash pins
`timescale 1ns/1ps
module spi_host_model
(
  // Clock and lane mode
  input wire i_clk,
  input wire i_quad,
  // Flash pins
  output reg o_cs_n,
  output reg o_sclk,
  output reg [3:0] o_dq,
  input wire [3:0] i_dq
);
  integer k;
  initial
  begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_dq = 4'h0;
  end
  // Half period of four clocks keeps sclk under the synchroniser limit
  task frame(input [31:0] tx, input integer nb, input integer nr, output [23:0] rx);
    integer w;
    begin
      w = i_quad ? 4 : 1;
      rx = 24'h0;
      o_cs_n <= 1'b0;
      repeat (4) @(posedge i_clk);
      for (k = 0; k < (nb + 8 * nr) / w; k = k + 1)
      begin
        if (k * w < nb)
          o_dq <= i_quad ? tx[31 - 4 * k -: 4] : {o_dq[3:1], tx[31 - k]};
        repeat (4) @(posedge i_clk);
        o_sclk <= 1'b1;
        if (k * w >= nb)
          rx = i_quad ? {rx[19:0], i_dq} : {rx[22:0], i_dq[1]};
        repeat (4) @(posedge i_clk);
        o_sclk <= 1'b0;
      end
      repeat (4) @(posedge i_clk);
      o_cs_n <= 1'b1;
      o_dq <= ~o_dq;
      repeat (8) @(posedge i_clk);
    end
  endtask
endmodule // spi_host_model

// File: tb/tb.sv
// Self-checking bench for the flash command interpreter
`timescale 1ns/1ps
module tb;
  // Identity values are arbitrary
  localparam [7:0] SIG = 8'h3C;
  localparam [7:0] MKR = 8'hA5;
  localparam integer ECYC = 400;
  reg clk, rstn, prot, wes, busy, quad;
  reg [7:0] op;
  reg [31:0] seed;
  reg [23:0] rx;
  wire cs_n, sclk, write_enable_latch, write_in_progress, dsl, sec, ces, elk;
  wire [2:0] slk;
  wire [3:0] hdq, ddq, oe_n;
  wire [7:0] sst;
  integer err_total, num_checks, k;
  integer cyc = 0;
  integer n_start = 0;
  flash_cmd_ctrl #(.SIGNATURE(SIG), .MAKER_CODE(MKR), .MEM_TYPE(8'h41), .CAPACITY(8'h17),
    .ERASE_CYC(ECYC)) i_dut (.i_clk(clk), .i_rstn(rstn), .i_cs_n(cs_n), .i_sclk(sclk),
    .i_dq(hdq), .o_dq(ddq), .o_dq_oe_n(oe_n), .i_quad_peripheral_mode(quad),
    .i_any_block_protected(prot), .i_write_enable_set(wes), .i_other_busy(busy),
    .o_write_enable_latch(write_enable_latch), .o_write_in_progress(write_in_progress), .o_deep_sleep(dsl),
    .o_secure_mode(sec), .o_chip_erase_start(ces), .o_secure_status(sst),
    .o_sector_lock(slk), .o_extra_lock_bit(elk));
  // Undriven lines read back inverted so stale data cannot pass
  spi_host_model i_host (.i_clk(clk), .i_quad(quad), .o_cs_n(cs_n), .o_sclk(sclk), .o_dq(hdq),
    .i_dq(ddq ^ oe_n));
  function [31:0] xs(input [31:0] s);
    begin
      xs = s ^ (s << 13);
      xs = xs ^ (xs >> 17);
      xs = xs ^ (xs << 5);
    end
  endfunction
  function [23:0] lmap(input [7:0] d);
    lmap = {16'h0, d[7], 3'h0, d[3], d[2], d[1], 1'b0};
  endfunction
  task chk(input [63:0] nm, input [23:0] exp, input [23:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp)
      begin
        err_total = err_total + 1;
        $display("ERROR %0s exp %h got %h", nm, exp, got);
      end
    end
  endtask
  task wen;
    begin
      wes <= 1'b1;
      @(posedge clk);
      wes <= 1'b0;
      @(posedge clk);
    end
  endtask
  task cmd(input [7:0] c, input integer nr);
    i_host.frame({c, 24'h0}, 8, nr, rx);
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      err_total = err_total + 1;
      tally_and_finish;
    end
  end
  always @(posedge clk)
    if (ces === 1'b1)
      n_start <= n_start + 1;
  initial
  begin
    {rstn, prot, wes, busy, quad} = 5'h00;
    err_total = 0;
    num_checks = 0;
    seed = 32'h0000A99A;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    chk("standby", 24'h0, {dsl, write_in_progress, write_enable_latch});
    seed = xs(seed);
    i_host.frame({8'hAB, seed[23:0]}, 32, 2, rx);
    chk("sig", {8'h0, SIG, SIG}, rx);
    cmd(8'h9F, 3);
    chk("ident", {MKR, 16'h4117}, rx);
    quad <= 1'b1;
    @(posedge clk);
    cmd(8'h9F, 3);
    chk("q_ident", {MKR, 16'h4117}, rx);
    quad <= 1'b0;
    @(posedge clk);
    for (k = 0; k < 2; k = k + 1)
    begin
      i_host.frame({8'h90, 23'h0, k[0]}, 32, 4, rx);
      chk("mfr_dev", k ? {MKR, SIG, MKR} : {SIG, MKR, SIG}, rx);
    end
    $display("identification tests done");
    for (k = 0; k < 2; k = k + 1)
    begin
      op = k ? 8'h60 : 8'hC7;
      cmd(op, 0);
      chk("no_wel", 24'h0, write_in_progress);
      wen;
      prot <= 1'b1;
      cmd(op, 0);
      prot <= 1'b0;
      chk("prot", 24'h0, write_in_progress);
      i_host.frame({op, 24'h0}, 9, 0, rx);
      chk("late_cs", 24'h0, write_in_progress);
      cmd(op, 0);
      chk("erasing", 24'h1, write_in_progress);
      cmd(8'hB9, 0);
      repeat (70) @(posedge clk);
      chk("busy_dp", 24'h1, {dsl, write_in_progress});
      while (write_in_progress === 1'b1 && cyc < 60000)
        @(posedge clk);
      chk("erased", 24'h0, {write_in_progress, write_enable_latch});
    end
    busy <= 1'b1;
    cmd(8'hB9, 0);
    repeat (70) @(posedge clk);
    busy <= 1'b0;
    chk("busy_in", 24'h0, dsl);
    $display("erase tests done");
    cmd(8'hB9, 0);
    repeat (45) @(posedge clk);
    chk("dp_early", 24'h0, dsl);
    repeat (25) @(posedge clk);
    chk("dp_on", 24'h1, dsl);
    wen;
    cmd(8'hC7, 0);
    chk("dp_erase", 24'h1, {write_in_progress, dsl});
    cmd(8'hAB, 0);
    repeat (70) @(posedge clk);
    chk("woken", 24'h0, dsl);
    $display("sleep tests done");
    cmd(8'h3A, 0);
    chk("secure", 24'h1, sec);
    wen;
    cmd(8'hC7, 0);
    chk("sec_ce", 24'h0, write_in_progress);
    seed = xs(seed);
    wen;
    i_host.frame({8'h01, seed[7:0], 16'h0}, 16, 0, rx);
    chk("locks", lmap(seed[7:0]), sst);
    chk("lockpins", {20'h0, seed[1], seed[2], seed[7], seed[3]}, {slk, elk});
    wen;
    i_host.frame(32'h01000000, 16, 0, rx);
    chk("sticky", lmap(seed[7:0]), sst);
    cmd(8'h04, 0);
    chk("sec_exit", 24'h0, sec);
    $display("secure tests done");
    chk("starts", 24'h2, n_start);
    tally_and_finish;
  end
endmodule // tb
bind flash_cmd_ctrl flash_cmd_ctrl_assertions #(.ERASE_CYC(ERASE_CYC)) i_chk (
  .i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(i_cs_n),
  .i_any_block_protected(i_any_block_protected), .o_dq_oe_n(o_dq_oe_n),
  .o_write_enable_latch(o_write_enable_latch), .o_write_in_progress(o_write_in_progress),
  .o_deep_sleep(o_deep_sleep), .o_secure_mode(o_secure_mode),
  .o_chip_erase_start(o_chip_erase_start), .o_secure_status(o_secure_status),
  .o_sector_lock(o_sector_lock), .o_extra_lock_bit(o_extra_lock_bit));
